// ==== src/ufbfc_pkg.sv ====
// Package: register map, field positions, reset values and encodings of the serial config block
package ufbfc_pkg;
  // Bus geometry
  localparam int UFBFC_AW = 5;
  localparam int UFBFC_DW = 32;
  // Register byte offsets
  localparam logic [UFBFC_AW-1:0] OFS_SPEED = 5'h00;
  localparam logic [UFBFC_AW-1:0] OFS_TXRX = 5'h04;
  localparam logic [UFBFC_AW-1:0] OFS_FRAME = 5'h08;
  localparam logic [UFBFC_AW-1:0] OFS_FLOW = 5'h0c;
  localparam logic [UFBFC_AW-1:0] OFS_BAUD_LO = 5'h10;
  localparam logic [UFBFC_AW-1:0] OFS_BAUD_HI = 5'h14;
  localparam logic [UFBFC_AW-1:0] OFS_DATA = 5'h18;
  localparam logic [UFBFC_AW-1:0] OFS_STAT = 5'h1c;
  // Field positions
  localparam int SPD_DOUBLE = 1;
  localparam int TXRX_RXEN = 4;
  localparam int TXRX_TXEN = 3;
  localparam int TXRX_SIZE2 = 2;
  localparam int FRM_MODE_LO = 6;
  localparam int FRM_SIZE_LO = 1;
  localparam int FRM_POL = 0;
  localparam int FLOW_CTS = 1;
  localparam int FLOW_RTS = 0;
  localparam int DATA_FERR = 9;
  localparam int ST_RXAVAIL = 0;
  localparam int ST_TXEMPTY = 1;
  localparam int ST_TXIDLE = 2;
  localparam int ST_OVERRUN = 3;
  localparam int ST_CTS = 4;
  localparam int ST_RTS = 5;
  localparam int ST_NBITS_LO = 8;
  // Reset values
  localparam logic [7:0] SPEED_RST = 8'h00;
  localparam logic [7:0] TXRX_RST = 8'h00;
  localparam logic [7:0] FRAME_RST = 8'h06;
  localparam logic [1:0] FLOW_RST = 2'h0;
  localparam logic [7:0] BAUD_LO_RST = 8'h00;
  localparam logic [3:0] BAUD_HI_RST = 4'h0;
  // Divisor and oversampling
  localparam int DIV_W = 12;
  localparam logic [4:0] OVS_NORMAL = 5'h10;
  localparam logic [4:0] OVS_DOUBLE = 5'h08;
  localparam int CHAR_W = 9;
  localparam int BUF_W = 10;
  localparam int BUF_DEPTH = 2;
  // Character size codes and data bit counts
  localparam logic [2:0] SZ_5 = 3'h0;
  localparam logic [2:0] SZ_6 = 3'h1;
  localparam logic [2:0] SZ_7 = 3'h2;
  localparam logic [2:0] SZ_8 = 3'h3;
  localparam logic [2:0] SZ_9 = 3'h7;
  localparam logic [3:0] NB_5 = 4'h5;
  localparam logic [3:0] NB_6 = 4'h6;
  localparam logic [3:0] NB_7 = 4'h7;
  localparam logic [3:0] NB_8 = 4'h8;
  localparam logic [3:0] NB_9 = 4'h9;
  // Operating modes
  typedef enum logic [1:0] {
    MODE_ASYNC = 2'h0,
    MODE_SYNC = 2'h1,
    MODE_RSVD = 2'h2,
    MODE_SPI = 2'h3
  } ufbfc_mode_t;
  // Frame engine states, Gray coded along idle-start-data-stop
  typedef enum logic [1:0] {
    FS_IDLE = 2'h0,
    FS_START = 2'h1,
    FS_DATA = 2'h3,
    FS_STOP = 2'h2
  } ufbfc_state_t;
endpackage : ufbfc_pkg

// ==== src/ufbfc_stream_if.sv ====
// Interface: valid/ready word stream between the frame engine and its buffer
interface ufbfc_stream_if #(parameter int W = 10);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ufbfc_stream_if

// ==== src/ufbfc_pair_buf.sv ====
// Module: small register buffer with valid/ready on both sides
module ufbfc_pair_buf #(
  parameter int W = 10,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  ufbfc_stream_if.snk fill, // Filling side
  ufbfc_stream_if.src drain // Draining side
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Depth must be a power of two for pointer wrap
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin : g_bad_cfg
    $error("ufbfc_pair_buf: DEPTH must be a power of two of at least 2");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  wire push = fill.valid & fill.ready;
  wire pop = drain.valid & drain.ready;

  // Honest full and empty from the occupancy count
  assign fill.ready = (cnt_q < (PW+1)'(DEPTH));
  assign drain.valid = (cnt_q != '0);
  assign drain.data = mem_q[rd_q];

  // Storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= fill.data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule : ufbfc_pair_buf

// ==== src/ufbfc_core.sv ====
// Module: serial transceiver with frame format, baud divisor and CTS/RTS flow control
// Functional notes
// - Size code 000..011 gives five to eight bits, 111 nine; 100..110 reserved.
// - Synchronous, polarity 0: change data on rising clock, sample on falling; 1 swaps.
// - With CTS flow control on, a transmission starts only while CTS input is low.
// - With CTS flow control off, CTS is ignored and transmission always allowed.
// - Flow register bit 0 switches the RTS receive handshake on or off.
// - Twelve-bit divisor: high register gives top nibble, low register bottom byte.
// - Writing the low divisor register reloads the prescaler at once; high write doesn't.
// - Double speed in asynchronous mode cuts prescaler ticks per bit from 16 to 8.
// - Mode field: 00 async, 01 sync, 10 reserved, 11 master SPI.
module ufbfc_core
  import ufbfc_pkg::*;
(
  input wire logic clk_sys, // System clock, 50 MHz
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [UFBFC_AW-1:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lane selects
  input wire logic [UFBFC_DW-1:0] wb_dat_i, // Write data
  output logic [UFBFC_DW-1:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic serial_rx_pin, // Receive data pin
  output logic serial_tx_pin, // Transmit data pin
  input wire logic cts_n_pin, // Clear to send, active low
  output logic rts_n_pin, // Request to send, active low
  input wire logic external_serial_clock_in, // Serial clock pin level
  output logic external_serial_clock_out, // Serial clock driven in SPI mode
  output logic external_serial_clock_oe // Serial clock output enable
);

  // Control registers
  logic [7:0] speed_q;
  logic [7:0] txrx_q;
  logic [7:0] frame_q;
  logic [1:0] flow_q;
  logic [7:0] baud_lo_q;
  logic [3:0] baud_hi_q;
  logic [DIV_W-1:0] presc_q;
  logic [CHAR_W-1:0] tx_hold_q;
  logic tx_hold_v_q;
  logic overrun_q;
  // Bus slave state
  logic ack_q;
  logic [UFBFC_DW-1:0] dat_q;
  // Pin synchronisers
  logic rx_s1_q, rx_s2_q;
  logic cts_s1_q, cts_s2_q;
  logic xck_s1_q, xck_s2_q;
  logic sclk_prev_q;
  logic xck_out_q;
  logic xck_oe_q;
  logic rts_n_q;
  // Transmit engine
  ufbfc_state_t tx_st_q;
  logic [CHAR_W-1:0] tx_data_q;
  logic [3:0] tx_idx_q;
  logic [4:0] tx_os_q;
  logic txd_q;
  // Receive engine
  ufbfc_state_t rx_st_q;
  logic [CHAR_W-1:0] rx_sh_q;
  logic [3:0] rx_idx_q;
  logic [4:0] rx_os_q;

  // Data bits per character from the three-bit size code
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    case (code)
      SZ_5: char_bits = NB_5;
      SZ_6: char_bits = NB_6;
      SZ_7: char_bits = NB_7;
      SZ_8: char_bits = NB_8;
      SZ_9: char_bits = NB_9;
      default: char_bits = NB_8; // Reserved codes behave as eight bits
    endcase
  endfunction : char_bits

  // Byte-wide register write helper honouring the low lane select
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [UFBFC_DW-1:0] wd,
                                       input logic [3:0] sel);
    lane0 = sel[0] ? wd[7:0] : old;
  endfunction : lane0

  // Receive buffer between the receive engine and the data register
  ufbfc_stream_if #(.W(BUF_W)) rx_fill ();
  ufbfc_stream_if #(.W(BUF_W)) rx_drain ();
  ufbfc_pair_buf #(.W(BUF_W), .DEPTH(BUF_DEPTH)) u_rx_buf (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .fill(rx_fill),
    .drain(rx_drain)
  );

  // Bus decode: a request is answered one cycle later, and commits at the ack edge
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_new = bus_req & ~ack_q;
  wire bus_commit = bus_req & ack_q;
  wire wr_commit = bus_commit & wb_we_i;
  wire rd_commit = bus_commit & ~wb_we_i;
  wire hit_speed = (wb_adr_i == OFS_SPEED);
  wire hit_txrx = (wb_adr_i == OFS_TXRX);
  wire hit_frame = (wb_adr_i == OFS_FRAME);
  wire hit_flow = (wb_adr_i == OFS_FLOW);
  wire hit_baud_lo = (wb_adr_i == OFS_BAUD_LO);
  wire hit_baud_hi = (wb_adr_i == OFS_BAUD_HI);
  wire hit_data = (wb_adr_i == OFS_DATA);
  wire hit_stat = (wb_adr_i == OFS_STAT);
  wire wr_lane0 = wr_commit & wb_sel_i[0];

  // Mode and format decode
  wire [1:0] mode_bits = frame_q[FRM_MODE_LO +: 2];
  wire mode_async = (mode_bits == MODE_ASYNC);
  wire mode_sync = (mode_bits == MODE_SYNC);
  wire mode_spi = (mode_bits == MODE_SPI);
  wire mode_ok = ~(mode_bits == MODE_RSVD); // Reserved mode blocks new transmit starts and holds the receive engine idle
  wire pol = frame_q[FRM_POL] & mode_sync;
  wire [2:0] size_code = {txrx_q[TXRX_SIZE2], frame_q[FRM_SIZE_LO +: 2]};
  wire [3:0] nbits = char_bits(size_code);
  wire tx_en = txrx_q[TXRX_TXEN] & mode_ok;
  wire rx_en = txrx_q[TXRX_RXEN] & mode_ok;
  wire dbl = speed_q[SPD_DOUBLE] & mode_async;
  wire [4:0] ovs = dbl ? OVS_DOUBLE : OVS_NORMAL;
  wire [4:0] ovs_last = ovs - 5'h01;
  wire [4:0] half_last = (ovs >> 1) - 5'h01;
  wire [DIV_W-1:0] divisor = {baud_hi_q, baud_lo_q};
  wire [DIV_W-1:0] divisor_new = {baud_hi_q, wb_dat_i[7:0]};
  wire baud_tick = (presc_q == '0);

  // Serial clock edges: external pin in sync mode, own clock in SPI mode
  wire sclk_lvl = mode_spi ? xck_out_q : xck_s2_q;
  wire sclk_rise = sclk_lvl & ~sclk_prev_q;
  wire sclk_fall = ~sclk_lvl & sclk_prev_q;
  wire chg_edge = pol ? sclk_fall : sclk_rise;
  wire smp_edge = pol ? sclk_rise : sclk_fall;

  // Bit events of both engines
  wire tx_ev = mode_async ? (baud_tick & (tx_os_q == ovs_last)) : chg_edge;
  wire rx_ev = mode_async ? (baud_tick & (rx_os_q == '0)) : smp_edge;
  wire cts_ok = ~flow_q[FLOW_CTS] | ~cts_s2_q;
  wire tx_start = tx_en & tx_hold_v_q & (tx_st_q == FS_IDLE) & cts_ok;
  wire rx_begin_async = mode_async & baud_tick & ~rx_s2_q;
  wire rx_begin_sync = ~mode_async & smp_edge & ~rx_s2_q;
  wire rx_done = (rx_st_q == FS_STOP) & rx_ev;

  // Receive buffer hookup: overrun when the buffer has no room at stop
  assign rx_fill.valid = rx_done & rx_en;
  assign rx_fill.data = {~rx_s2_q, rx_sh_q};
  assign rx_drain.ready = rd_commit & hit_data;

  // Read selection
  wire [UFBFC_DW-1:0] stat_word = {20'h00000, nbits, 2'h0, ~rts_n_q, ~cts_s2_q, overrun_q,
                                   tx_st_q == FS_IDLE, ~tx_hold_v_q, rx_drain.valid};
  wire [UFBFC_DW-1:0] data_word = rx_drain.valid ? {22'h000000, rx_drain.data} : '0;
  wire [UFBFC_DW-1:0] rd_word =
      hit_speed ? {24'h000000, speed_q} :
      hit_txrx ? {24'h000000, txrx_q} :
      hit_frame ? {24'h000000, frame_q} :
      hit_flow ? {30'h00000000, flow_q} :
      hit_baud_lo ? {24'h000000, baud_lo_q} :
      hit_baud_hi ? {28'h0000000, baud_hi_q} :
      hit_data ? data_word :
      hit_stat ? stat_word : '0;

  // Bus answer: ack one cycle after the request, dropped after one cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= bus_new;
      dat_q <= bus_new ? rd_word : '0;
    end
  end

  // Format and enable registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      speed_q <= SPEED_RST;
      txrx_q <= TXRX_RST;
      frame_q <= FRAME_RST;
    end else if (wr_commit) begin
      if (hit_speed) speed_q <= lane0(speed_q, wb_dat_i, wb_sel_i) & 8'h02;
      if (hit_txrx) txrx_q <= lane0(txrx_q, wb_dat_i, wb_sel_i) & 8'h1c;
      if (hit_frame) frame_q <= lane0(frame_q, wb_dat_i, wb_sel_i);
    end
  end

  // Flow control enables, upper bits not stored
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      flow_q <= FLOW_RST;
    end else if (wr_lane0 && hit_flow) begin
      flow_q <= wb_dat_i[1:0];
    end
  end

  // Divisor registers, reserved nibble never stored
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      baud_lo_q <= BAUD_LO_RST;
      baud_hi_q <= BAUD_HI_RST;
    end else if (wr_lane0) begin
      if (hit_baud_lo) baud_lo_q <= wb_dat_i[7:0];
      if (hit_baud_hi) baud_hi_q <= wb_dat_i[3:0];
    end
  end

  // Prescaler: counts down, low byte write reloads it with the new divisor
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      presc_q <= '0;
    end else if (wr_lane0 && hit_baud_lo) begin
      presc_q <= divisor_new;
    end else if (baud_tick) begin
      presc_q <= divisor;
    end else begin
      presc_q <= presc_q - 1'b1;
    end
  end

  // Pin synchronisers, two flops before any logic
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      cts_s1_q <= 1'b1;
      cts_s2_q <= 1'b1;
      xck_s1_q <= 1'b0;
      xck_s2_q <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      rx_s1_q <= serial_rx_pin;
      rx_s2_q <= rx_s1_q;
      cts_s1_q <= cts_n_pin;
      cts_s2_q <= cts_s1_q;
      xck_s1_q <= external_serial_clock_in;
      xck_s2_q <= xck_s1_q;
      sclk_prev_q <= sclk_lvl;
    end
  end

  // Own serial clock in SPI mode, toggles on each prescaler tick
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      xck_out_q <= 1'b0;
      xck_oe_q <= 1'b0;
    end else begin
      xck_oe_q <= mode_spi;
      xck_out_q <= mode_spi ? (xck_out_q ^ baud_tick) : 1'b0;
    end
  end

  // RTS: with the handshake on, asserted while the receive buffer has room; held asserted with it off
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rts_n_q <= 1'b0;
    end else begin
      rts_n_q <= flow_q[FLOW_RTS] ? ~rx_fill.ready : 1'b0;
    end
  end

  // Transmit holding word and sticky overrun, set wins over clear
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tx_hold_q <= '0;
      tx_hold_v_q <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      if (wr_lane0 && hit_data && !tx_hold_v_q) begin
        tx_hold_q <= wb_dat_i[CHAR_W-1:0];
        tx_hold_v_q <= 1'b1;
      end else if (tx_start) begin
        tx_hold_v_q <= 1'b0;
      end
      if (rx_fill.valid && !rx_fill.ready) overrun_q <= 1'b1;
      else if (wr_lane0 && hit_stat && wb_dat_i[ST_OVERRUN]) overrun_q <= 1'b0;
    end
  end

  // Transmit oversample counter, restarted with each frame
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tx_os_q <= '0;
    end else if (tx_start) begin
      tx_os_q <= '0;
    end else if (baud_tick) begin
      tx_os_q <= (tx_os_q == ovs_last) ? 5'h00 : tx_os_q + 5'h01;
    end
  end

  // Transmit frame engine: start bit, data bits LSB first, stop bit
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tx_st_q <= FS_IDLE;
      tx_data_q <= '0;
      tx_idx_q <= '0;
      txd_q <= 1'b1;
    end else begin
      case (tx_st_q)
        FS_IDLE: begin
          if (tx_start) begin
            tx_data_q <= tx_hold_q;
            txd_q <= 1'b0;
            tx_st_q <= FS_START;
          end
        end
        FS_START: begin
          if (tx_ev) begin
            txd_q <= tx_data_q[0];
            tx_idx_q <= '0;
            tx_st_q <= FS_DATA;
          end
        end
        FS_DATA: begin
          if (tx_ev && tx_idx_q == nbits - 4'h1) begin
            txd_q <= 1'b1;
            tx_st_q <= FS_STOP;
          end else if (tx_ev) begin
            txd_q <= tx_data_q[tx_idx_q + 4'h1];
            tx_idx_q <= tx_idx_q + 4'h1;
          end
        end
        FS_STOP: begin
          if (tx_ev) tx_st_q <= FS_IDLE;
        end
        default: tx_st_q <= FS_IDLE;
      endcase
    end
  end

  // Receive oversample counter: half a bit to the start centre, then whole bits
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rx_os_q <= '0;
    end else if (rx_st_q == FS_IDLE && rx_begin_async) begin
      rx_os_q <= half_last;
    end else if (baud_tick) begin
      rx_os_q <= (rx_os_q == '0) ? ovs_last : rx_os_q - 5'h01;
    end
  end

  // Receive frame engine
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rx_st_q <= FS_IDLE;
      rx_sh_q <= '0;
      rx_idx_q <= '0;
    end else if (!rx_en) begin
      rx_st_q <= FS_IDLE;
    end else begin
      case (rx_st_q)
        FS_IDLE: begin
          rx_idx_q <= '0;
          if (rx_begin_async) begin
            rx_sh_q <= '0;
            rx_st_q <= FS_START;
          end else if (rx_begin_sync) begin
            rx_sh_q <= '0;
            rx_st_q <= FS_DATA;
          end
        end
        FS_START: begin
          if (rx_ev) rx_st_q <= rx_s2_q ? FS_IDLE : FS_DATA; // False start is dropped
        end
        FS_DATA: begin
          if (rx_ev) begin
            rx_sh_q[rx_idx_q] <= rx_s2_q;
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == nbits - 4'h1) rx_st_q <= FS_STOP;
          end
        end
        FS_STOP: begin
          if (rx_ev) rx_st_q <= FS_IDLE;
        end
        default: rx_st_q <= FS_IDLE;
      endcase
    end
  end

  // Outputs straight from flops
  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign serial_tx_pin = txd_q;
  assign rts_n_pin = rts_n_q;
  assign external_serial_clock_out = xck_out_q;
  assign external_serial_clock_oe = xck_oe_q;

endmodule : ufbfc_core

// ==== testbench/ufbfc_core_sva.sv ====
// Checker: bus, flow control and serial clock relations of the serial config block
module ufbfc_core_sva
  import ufbfc_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [UFBFC_AW-1:0] wb_adr_i, // Address
  input wire logic [3:0] wb_sel_i, // Lanes
  input wire logic [UFBFC_DW-1:0] wb_dat_i, // Write data
  input wire logic [UFBFC_DW-1:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Ack
  input wire logic serial_rx_pin, // Receive line
  input wire logic serial_tx_pin, // Transmit line
  input wire logic cts_n_pin, // Clear to send
  input wire logic rts_n_pin, // Request to send
  input wire logic external_serial_clock_in, // Clock in
  input wire logic external_serial_clock_out, // Clock out
  input wire logic external_serial_clock_oe // Clock enable
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  logic [1:0] flow_q;
  logic [1:0] mode_q;
  logic [2:0] size_q;
  logic [8:0] high_q;
  // Ack strobes, expected bit count, long tx idle
  wire wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];
  wire rd_ack = wb_ack_o && !wb_we_i;
  wire [3:0] nb_exp = (size_q == SZ_9) ? NB_9 : size_q[2] ? NB_8 : NB_5 + {2'h0, size_q[1:0]};
  wire full_idle = high_q == 9'h1ff;
  // Shadow copies of the fields, committed at the ack edge as the block does
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      flow_q <= FLOW_RST;
      mode_q <= FRAME_RST[7:6];
      size_q <= {TXRX_RST[TXRX_SIZE2], FRAME_RST[2:1]};
    end else begin
      if (wr_ack && wb_adr_i == OFS_FLOW) flow_q <= wb_dat_i[1:0];
      if (wr_ack && wb_adr_i == OFS_FRAME) mode_q <= wb_dat_i[7:6];
      if (wr_ack && wb_adr_i == OFS_FRAME) size_q[1:0] <= wb_dat_i[2:1];
      if (wr_ack && wb_adr_i == OFS_TXRX) size_q[2] <= wb_dat_i[TXRX_SIZE2];
    end
  end
  // Saturating count of cycles with the transmit line high
  always_ff @(posedge clk_sys) begin
    high_q <= !rst_b || !serial_tx_pin ? 9'h000 : full_idle ? high_q : high_q + 9'h001;
  end
  ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == '0) else $error("read data outside ack");
  flow_read_a: assert property (rd_ack && wb_adr_i == OFS_FLOW |-> wb_dat_o == 32'(flow_q))
    else $error("flow register read wrong");
  div_high_a: assert property (rd_ack && wb_adr_i == OFS_BAUD_HI |-> wb_dat_o[31:4] == 28'h0)
    else $error("divisor high upper bits set");
  size_count_a: assert property (rd_ack && wb_adr_i == OFS_STAT |-> wb_dat_o[11:8] == nb_exp)
    else $error("bit count wrong");
  rts_off_a: assert property (!flow_q[0] && !$past(flow_q[0]) |-> !rts_n_pin)
    else $error("rts raised while off");
  cts_gate_a: assert property ((cts_n_pin && flow_q[1] && full_idle) [*4] |=> serial_tx_pin)
    else $error("start while cts high");
  spi_clock_a: assert property (mode_q == $past(mode_q) |-> external_serial_clock_oe == (mode_q == MODE_SPI))
    else $error("clock enable wrong for mode");
  reset_pins_a: assert property ($rose(rst_b) |-> serial_tx_pin && !rts_n_pin && !external_serial_clock_oe)
    else $error("pins wrong after reset");
  cover property (flow_q[1] && !serial_tx_pin);
  cover property (flow_q[0] && rts_n_pin);
  cover property (external_serial_clock_oe);
endmodule : ufbfc_core_sva

bind ufbfc_core ufbfc_core_sva ufbfc_core_sva_i (.*);

// ==== testbench/ufbfc_peer.sv ====
// Partner: remote serial transceiver with send, receive and clear-to-send control
module ufbfc_peer (
  input wire logic clk_sys, // Clock
  input wire logic tx_line, // Line from the block
  output logic rx_line, // Line into the block
  output logic cts_n // Clear to send, active low
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle line high, clear to send
  initial begin
    rx_line = 1'b1;
    cts_n = 1'b0;
  end
  // Drive clear to send, called just after a rising edge
  task automatic set_cts(input logic v);
    cts_n <= v;
  endtask : set_cts
  // Start bit, data LSB first, one stop bit
  task automatic send(input logic [8:0] d, input int nb, input int per);
    for (int i = -1; i <= nb; i++) begin
      rx_line <= (i < 0) ? 1'b0 : (i == nb) ? 1'b1 : d[i];
      repeat (per) @(posedge clk_sys);
    end
  endtask : send
  // Receive one frame; the start bit end sets the phase, so bit 0 must be 1
  task automatic recv(input int nb, input int per, output logic [8:0] d, output logic ok);
    int n;
    n = 0;
    d = '0;
    while (tx_line !== 1'b0 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    while (tx_line !== 1'b1 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    repeat (per / 2) @(negedge clk_sys);
    for (int i = 0; i < nb; i++) begin
      d[i] = tx_line;
      repeat (per) @(negedge clk_sys);
    end
    ok = (n < 3000) && (tx_line === 1'b1);
  endtask : recv
endmodule : ufbfc_peer

// ==== testbench/ufbfc_core_bench.sv ====
// Bench: register, transmit, receive and flow control scenarios of the serial config block
module ufbfc_core_bench
  import ufbfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [UFBFC_AW-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [UFBFC_DW-1:0] wb_dat_i = '0;
  logic [UFBFC_DW-1:0] wb_dat_o;
  logic wb_ack_o, serial_rx_pin, serial_tx_pin, cts_n_pin, rts_n_pin, sclk_out, sclk_oe;
  int bad_count = 0;
  int checked = 0;
  // Clock at 50 MHz
  always #10 clk_sys = ~clk_sys;
  ufbfc_core ufbfc_core_i (.*, .external_serial_clock_in(1'b1), .external_serial_clock_out(sclk_out),
    .external_serial_clock_oe(sclk_oe));
  ufbfc_peer ufbfc_peer_i (.clk_sys(clk_sys), .tx_line(serial_tx_pin), .rx_line(serial_rx_pin),
    .cts_n(cts_n_pin));
  task automatic end_sim();
    $display("Counts: %0d checked, %0d bad", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One classic cycle: hold until ack, take data at that edge, then release
  task automatic bus(input logic we, input logic [UFBFC_AW-1:0] a, input logic [31:0] d, input logic [3:0] sel,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 50) begin
        bad_count++;
        end_sim();
      end
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic wr(input logic [UFBFC_AW-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, 4'h1, r);
  endtask : wr
  task automatic rdc(input logic [UFBFC_AW-1:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, '0, 4'h1, r);
    chk(r, e);
  endtask : rdc
  // Reset values, read-only bits, lane select and unmapped space
  task automatic t_regs();
    logic [31:0] r;
    rdc(OFS_FLOW, 32'h0);
    rdc(OFS_BAUD_HI, 32'h0);
    rdc(OFS_BAUD_LO, 32'h0);
    rdc(OFS_FRAME, 32'h6);
    wr(OFS_FLOW, 32'hff);
    rdc(OFS_FLOW, 32'h3);
    bus(1'b1, OFS_FLOW, 32'h0, 4'h0, r);
    rdc(OFS_FLOW, 32'h3);
    wr(OFS_FLOW, 32'h0);
    wr(OFS_BAUD_HI, 32'h0a);
    wr(OFS_BAUD_LO, 32'h5c);
    rdc(OFS_BAUD_HI, 32'h0a);
    rdc(OFS_BAUD_LO, 32'h5c);
    rdc(5'h02, 32'h0);
    $display("Test regs done");
  endtask : t_regs
  // Size codes 000..011, 111 and reserved 100 over the line at 32 clocks a bit, then double speed at 16
  task automatic t_tx();
    logic [2:0] code [6] = '{SZ_5, SZ_6, SZ_7, SZ_8, SZ_9, 3'h4};
    int nbits [6] = '{5, 6, 7, 8, 9, 8};
    logic [31:0] r;
    logic [8:0] d;
    logic ok;
    wr(OFS_BAUD_HI, 32'h0);
    wr(OFS_BAUD_LO, 32'h1);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_TXRX, {28'h0, 1'b1, code[i][2], 2'h0});
      wr(OFS_FRAME, {29'h0, code[i][1:0], 1'b0});
      bus(1'b0, OFS_STAT, '0, 4'h1, r);
      chk(r[ST_NBITS_LO +: 4], nbits[i][3:0]);
      wr(OFS_DATA, 32'h1b5);
      ufbfc_peer_i.recv(nbits[i], 32, d, ok);
      chk(d, 9'h1b5 & ((9'h1 << nbits[i]) - 9'h1));
      chk(ok, 1'b1);
    end
    wr(OFS_SPEED, 32'h2);
    wr(OFS_DATA, 32'h0a7);
    ufbfc_peer_i.recv(8, 16, d, ok);
    chk({ok, d}, 10'h2a7);
    wr(OFS_SPEED, 32'h0);
    $display("Test tx done");
  endtask : t_tx
  // Start held off while clear-to-send is high, ignored when gating is off
  task automatic t_cts();
    logic [8:0] d;
    logic ok;
    int lows;
    lows = 0;
    wr(OFS_FRAME, 32'h06);
    wr(OFS_TXRX, 32'h08);
    @(posedge clk_sys);
    ufbfc_peer_i.set_cts(1'b1);
    wr(OFS_FLOW, 32'h2);
    wr(OFS_DATA, 32'h05b);
    repeat (600) begin
      @(negedge clk_sys);
      if (serial_tx_pin !== 1'b1) lows++;
    end
    chk(lows, 0);
    @(posedge clk_sys);
    ufbfc_peer_i.set_cts(1'b0);
    ufbfc_peer_i.recv(8, 32, d, ok);
    chk({ok, d}, 10'h25b);
    wr(OFS_FLOW, 32'h0);
    @(posedge clk_sys);
    ufbfc_peer_i.set_cts(1'b1);
    wr(OFS_DATA, 32'h0c9);
    ufbfc_peer_i.recv(8, 32, d, ok);
    chk({ok, d}, 10'h2c9);
    $display("Test cts done");
  endtask : t_cts
  // Fill the receive buffer past full, toggle the handshake, then drain it
  task automatic t_rx();
    logic [31:0] r;
    wr(OFS_TXRX, 32'h10);
    wr(OFS_FLOW, 32'h1);
    @(posedge clk_sys);
    ufbfc_peer_i.send(9'h05a, 8, 32);
    ufbfc_peer_i.send(9'h0c3, 8, 32);
    repeat (4) @(negedge clk_sys);
    chk(rts_n_pin, 1'b1);
    @(posedge clk_sys);
    ufbfc_peer_i.send(9'h011, 8, 32);
    bus(1'b0, OFS_STAT, '0, 4'h1, r);
    chk(r[ST_OVERRUN], 1'b1);
    wr(OFS_FLOW, 32'h0);
    repeat (3) @(negedge clk_sys);
    chk(rts_n_pin, 1'b0);
    wr(OFS_FLOW, 32'h1);
    repeat (3) @(negedge clk_sys);
    chk(rts_n_pin, 1'b1);
    rdc(OFS_DATA, 32'h05a);
    rdc(OFS_DATA, 32'h0c3);
    rdc(OFS_DATA, 32'h0);
    repeat (3) @(negedge clk_sys);
    chk(rts_n_pin, 1'b0);
    wr(OFS_STAT, 32'h08);
    bus(1'b0, OFS_STAT, '0, 4'h1, r);
    chk(r[ST_OVERRUN], 1'b0);
    $display("Test rx done");
  endtask : t_rx
  // Serial clock pin driven only in SPI mode
  task automatic t_spi();
    wr(OFS_FRAME, 32'hc6);
    repeat (3) @(negedge clk_sys);
    chk(sclk_oe, 1'b1);
    wr(OFS_FRAME, 32'h06);
    repeat (3) @(negedge clk_sys);
    chk(sclk_oe, 1'b0);
    $display("Test spi done");
  endtask : t_spi
  // Reset for 6 cycles, then the scenarios
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_regs();
    t_tx();
    t_cts();
    t_rx();
    t_spi();
    end_sim();
  end
endmodule : ufbfc_core_bench
